// *** disk_select_if.sv ***
// Drive select, cylinder address and rotational position interface
`timescale 1ns/1ps
module disk_select_if import disk_select_pkg::*; (
    input logic clk,
    input logic rst_n,
    input logic [ADDR_W-1:0] regAddr,
    input logic [DATA_W-1:0] regWrData,
    input logic regWr,
    input logic regRd,
    output logic [DATA_W-1:0] regRdData,
    input logic index_pulse_n,
    input logic sector_pulse_n,
    input logic [SECTOR_W-1:0] sector_addr_n,
    input logic drive_fault_n,
    input logic write_protect_n,
    input logic drive1_swap_jumper_n,
    input logic drive2_swap_jumper_n,
    input logic cyl_addr_ack_n,
    input logic on_cylinder_n,
    input logic read_data_n,
    input logic read_clock_n,
    output logic drive1_select_n,
    output logic drive2_select_n,
    output logic platter_select_n,
    output logic surface_select_n,
    output logic [CYL_W-1:0] cyl_addr_n,
    output logic cyl_addr_strobe_n,
    output logic restore_n,
    output logic read_gate_n,
    output logic write_gate_n,
    output logic erase_gate_n
);
    localparam int SETTLE_W = $clog2(HEAD_SETTLE_CYC + 1);
    localparam int REST_W = $clog2(RESTORE_CYC + 1);
    localparam logic [SETTLE_W-1:0] SETTLE_DONE = SETTLE_W'(HEAD_SETTLE_CYC);
    localparam logic [REST_W-1:0] REST_LAST = REST_W'(RESTORE_CYC - 1);

    // Whole block state, every output comes from here
    typedef struct packed {
        state_t st;
        select_t sel;
        logic [UNIT_W-1:0] unitCode;
        logic [CYL_W-1:0] cyl;
        logic [SECTOR_W-1:0] target;
        logic headLower;
        logic [SETTLE_W-1:0] settleCnt;
        logic [REST_W-1:0] restCnt;
        logic strobe;
        logic restore;
        logic readGate;
        logic writeGate;
        logic armWrite;
        logic sectorPrev;
        logic indexPrev;
        logic found;
        logic indexSeen;
        logic sectorSeen;
        logic cylInvalid;
        logic protectHit;
        logic wordReady;
        logic [DATA_W-1:0] word;
        logic [DATA_W-1:0] rdData;
    } block_t;

    block_t r;
    block_t n;

    drive_in_t pinRaw; // Pins gathered as they arrive
    drive_in_t pin; // Same pins after two flip-flops
    logic sectorEdge; // Leading edge of the sector mark
    logic indexEdge; // Leading edge of the index mark
    logic [SECTOR_W-1:0] sectorNow; // Drive sector address, true sense
    logic settled; // Head select has stood long enough
    logic busySeek; // Carriage motion owned by us
    logic capValid; // A whole read word arrived
    logic [DATA_W-1:0] capWord; // The word itself
    logic [DATA_W-1:0] statusWord; // Status as software reads it

    // Bundle the pins so one synchroniser serves them all
    always_comb
    begin
        pinRaw.indexN = index_pulse_n;
        pinRaw.sectorN = sector_pulse_n;
        pinRaw.sectorAddrN = sector_addr_n;
        pinRaw.faultN = drive_fault_n;
        pinRaw.writeProtectN = write_protect_n;
        pinRaw.swap1N = drive1_swap_jumper_n;
        pinRaw.swap2N = drive2_swap_jumper_n;
        pinRaw.ackN = cyl_addr_ack_n;
        pinRaw.onCylN = on_cylinder_n;
        pinRaw.readDataN = read_data_n;
        pinRaw.readClockN = read_clock_n;
    end

    // Every drive input is asynchronous to the core clock
    sync2 #(.W($bits(drive_in_t))) pinSync (
        .clk(clk),
        .rst_n(rst_n),
        .d(pinRaw),
        .q(pin)
    );

    // Read bits framed by the recovered clock, only under read gate
    read_capture #(.W(DATA_W)) capture (
        .clk(clk),
        .rst_n(rst_n),
        .enable(r.readGate),
        .readClockN(pin.readClockN),
        .readDataN(pin.readDataN),
        .word(capWord),
        .wordValid(capValid)
    );

    // Derived conditions used by the sequencer
    always_comb
    begin
        // Falling edge of the active-low marks
        sectorEdge = r.sectorPrev & ~pin.sectorN;
        indexEdge = r.indexPrev & ~pin.indexN;
        // Address bits may skew through the synchroniser, but the drive
        // holds them still for microseconds around the mark
        sectorNow = ~pin.sectorAddrN;
        settled = (r.settleCnt == SETTLE_DONE);
        busySeek = (r.st == SEEK) || (r.st == RESTORE);
        statusWord = '0;
        statusWord[SECTOR_W-1:0] = sectorNow;
        statusWord[6] = r.found;
        statusWord[7] = ~pin.faultN;
        statusWord[8] = ~pin.writeProtectN;
        statusWord[9] = ~pin.ackN;
        statusWord[10] = ~pin.onCylN;
        statusWord[11] = r.indexSeen;
        statusWord[12] = r.sectorSeen;
        statusWord[13] = r.wordReady;
        statusWord[14] = r.cylInvalid;
        statusWord[15] = r.protectHit;
    end

    // Next state of the whole block
    always_comb
    begin
        n = r;
        n.sectorPrev = pin.sectorN;
        n.indexPrev = pin.indexN;
        n.rdData = '0;

        // Head select timer runs until it saturates
        if (!settled)
            n.settleCnt = r.settleCnt + 1'b1;

        // Register reads, data stands one cycle only
        if (regRd)
        begin
            case (regAddr)
                UNIT_OFS: n.rdData = DATA_W'(r.unitCode);
                CYL_OFS: n.rdData = DATA_W'(r.cyl);
                CTRL_OFS: n.rdData = DATA_W'({r.headLower, 3'h0,
                    r.armWrite, r.st == WAIT_SECTOR, r.restore, r.strobe});
                TARGET_OFS: n.rdData = DATA_W'(r.target);
                STATUS_OFS: n.rdData = statusWord;
                WORD_OFS:
                begin
                    n.rdData = r.word;
                    // Reading the word consumes it
                    n.wordReady = 1'b0;
                end
                default: n.rdData = '0; // Unmapped reads as zero
            endcase
        end

        // Register writes
        if (regWr)
        begin
            case (regAddr)
                UNIT_OFS:
                begin
                    // Illegal codes and busy periods leave selects alone
                    if ($onehot(regWrData[UNIT_W-1:0]) && r.st == IDLE)
                    begin
                        n.unitCode = regWrData[UNIT_W-1:0];
                        // Jumpers are read at this moment
                        n.sel = unitDecode(regWrData[UNIT_W-1:0],
                            pin.swap1N, pin.swap2N);
                    end
                end
                CYL_OFS:
                begin
                    // Address must not move under a pending strobe
                    if (!busySeek)
                    begin
                        if (regWrData[CYL_W-1:0] <= CYL_MAX)
                            n.cyl = regWrData[CYL_W-1:0];
                        else
                            n.cylInvalid = 1'b1;
                    end
                end
                TARGET_OFS:
                    n.target = regWrData[SECTOR_W-1:0];
                CTRL_OFS:
                begin
                    // Flag clear goes first so events this cycle win
                    if (regWrData[CTRL_CLEAR])
                    begin
                        n.indexSeen = 1'b0;
                        n.sectorSeen = 1'b0;
                        n.cylInvalid = 1'b0;
                        n.protectHit = 1'b0;
                        n.found = 1'b0;
                    end
                    if (r.st == IDLE)
                    begin
                        // Only one carriage command at a time
                        if (regWrData[CTRL_RESTORE])
                        begin
                            n.st = RESTORE;
                            n.restore = 1'b1;
                            n.strobe = 1'b1;
                            n.restCnt = '0;
                        end
                        else if (regWrData[CTRL_SEEK])
                        begin
                            n.st = SEEK;
                            n.strobe = 1'b1;
                        end
                        else if (regWrData[CTRL_READ] ||
                                 regWrData[CTRL_WRITE])
                        begin
                            n.st = WAIT_SECTOR;
                            n.armWrite = regWrData[CTRL_WRITE];
                            n.found = 1'b0;
                        end
                        // Head changes restart the settle time
                        if (regWrData[CTRL_HEAD] != r.headLower)
                        begin
                            n.headLower = regWrData[CTRL_HEAD];
                            n.settleCnt = '0;
                        end
                    end
                    else if (regWrData[CTRL_STOP] &&
                             (r.st == WAIT_SECTOR || r.st == TRANSFER))
                    begin
                        // Software abort of a pending or running transfer
                        n.st = IDLE;
                        n.readGate = 1'b0;
                        n.writeGate = 1'b0;
                    end
                end
                default: ; // Unmapped writes are dropped
            endcase
        end

        // Sticky rotational events, set wins over clear
        if (indexEdge)
            n.indexSeen = 1'b1;
        if (sectorEdge)
            n.sectorSeen = 1'b1;
        if (capValid)
        begin
            n.word = capWord;
            n.wordReady = 1'b1;
        end

        // Sequencer
        case (r.st)
            IDLE: ;
            SEEK:
            begin
                // Strobe stands until the drive accepts the address
                if (!pin.ackN)
                begin
                    n.strobe = 1'b0;
                    n.st = IDLE;
                end
            end
            RESTORE:
            begin
                // Restore and strobe stand together for the least time
                n.restCnt = r.restCnt + 1'b1;
                if (r.restCnt == REST_LAST)
                begin
                    n.restore = 1'b0;
                    n.strobe = 1'b0;
                    n.st = IDLE;
                end
            end
            WAIT_SECTOR:
            begin
                // Only a leading edge with the right address counts
                if (sectorEdge && sectorNow == r.target)
                begin
                    n.found = 1'b1;
                    if (!r.armWrite)
                    begin
                        n.readGate = 1'b1;
                        n.st = TRANSFER;
                    end
                    else if (!pin.writeProtectN)
                    begin
                        // Protected platter, the write is refused
                        n.protectHit = 1'b1;
                        n.st = IDLE;
                    end
                    else if (settled)
                    begin
                        n.writeGate = 1'b1;
                        n.st = TRANSFER;
                    end
                    // Unsettled head waits one more revolution
                end
            end
            TRANSFER:
            begin
                // A drive fault, or protect during a write, ends the transfer at once
                if (!pin.faultN || (r.writeGate && !pin.writeProtectN))
                begin
                    n.readGate = 1'b0;
                    n.writeGate = 1'b0;
                    n.protectHit = r.protectHit | pin.faultN;
                    n.st = IDLE;
                end
            end
            default: n.st = IDLE;
        endcase
    end

    // Single state register for the whole block
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
            r.st <= IDLE;
            r.sel <= SEL_NONE;
            r.sectorPrev <= 1'b1;
            r.indexPrev <= 1'b1;
        end
        else
            r <= n;
    end

    // Pins are active low; all come straight from the register
    assign drive1_select_n = r.sel.drive1SelN;
    assign drive2_select_n = r.sel.drive2SelN;
    assign platter_select_n = r.sel.platterSelN;
    assign surface_select_n = ~r.headLower;
    assign cyl_addr_n = ~r.cyl;
    assign cyl_addr_strobe_n = ~r.strobe;
    assign restore_n = ~r.restore;
    assign read_gate_n = ~r.readGate;
    // Erase always travels with write, never alone
    assign write_gate_n = ~r.writeGate;
    assign erase_gate_n = ~r.writeGate;
    assign regRdData = r.rdData;
endmodule

// *** disk_select_pkg.sv ***
// Shared constants, types and decode helper for the drive select interface
package disk_select_pkg;

    // Widths that more than one file depends on
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int UNIT_W = 4;
    localparam int CYL_W = 9;
    localparam int SECTOR_W = 6;

    // Register offsets on the plain register port
    localparam logic [ADDR_W-1:0] UNIT_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] CYL_OFS = 4'h1;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h2;
    localparam logic [ADDR_W-1:0] TARGET_OFS = 4'h3;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] WORD_OFS = 4'h5;

    // Command bits of the control register
    localparam int CTRL_SEEK = 0;
    localparam int CTRL_RESTORE = 1;
    localparam int CTRL_READ = 2;
    localparam int CTRL_WRITE = 3;
    localparam int CTRL_STOP = 4;
    localparam int CTRL_HEAD = 5;
    localparam int CTRL_CLEAR = 6;

    // Highest legal cylinder, innermost track
    localparam logic [CYL_W-1:0] CYL_MAX = 9'h197;

    // Timing, figures in nanoseconds, counts at the core clock rate
    localparam int CLK_MHZ = 40;
    localparam int HEAD_SETTLE_NS = 10000;
    localparam int RESTORE_NS = 1000;
    localparam int HEAD_SETTLE_CYC = (HEAD_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int RESTORE_CYC = (RESTORE_NS * CLK_MHZ + 999) / 1000;

    // Sequencer states
    typedef enum logic [2:0] {IDLE, SEEK, RESTORE, WAIT_SECTOR, TRANSFER}
        state_t;

    // Drive inputs as seen on the pins, all active low
    typedef struct packed {
        logic indexN;
        logic sectorN;
        logic [SECTOR_W-1:0] sectorAddrN;
        logic faultN;
        logic writeProtectN;
        logic swap1N;
        logic swap2N;
        logic ackN;
        logic onCylN;
        logic readDataN;
        logic readClockN;
    } drive_in_t;

    // Drive and platter select levels
    typedef struct packed {
        logic drive1SelN;
        logic drive2SelN;
        logic platterSelN;
    } select_t;

    // Nothing selected after reset
    localparam select_t SEL_NONE = '{1'b1, 1'b1, 1'b1};

    // One-hot unit code to select levels, the swap jumper of each drive flips its platter select
    function automatic select_t unitDecode(input logic [UNIT_W-1:0] code,
        input logic swap1N, input logic swap2N);
        select_t s;
        s.drive1SelN = ~(code[3] | code[2]);
        s.drive2SelN = ~(code[1] | code[0]);
        s.platterSelN = (code[3] | code[2]) ? (code[2] ^ ~swap1N)
                                            : (code[0] ^ ~swap2N);
        return s;
    endfunction

endpackage

// *** sync2.sv ***
// Two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module sync2 import disk_select_pkg::*; #(
    parameter int W = 1
) (
    input logic clk,
    input logic rst_n,
    input logic [W-1:0] d,
    output logic [W-1:0] q
);
    // Both stages; the first is read only by the second
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_t;

    sync_t r;
    sync_t n;

    // Next stage values
    always_comb
    begin
        n.meta = d;
        n.stable = r.meta;
    end

    // Reset to the idle (high) level of the active-low pins
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            r <= '1;
        else
            r <= n;
    end

    assign q = r.stable;
endmodule

// *** read_capture.sv ***
// Bit capture on recovered read clock and read data edges
`timescale 1ns/1ps
module read_capture import disk_select_pkg::*; #(
    parameter int W = DATA_W
) (
    input logic clk,
    input logic rst_n,
    input logic enable,
    input logic readClockN,
    input logic readDataN,
    output logic [W-1:0] word,
    output logic wordValid
);
    // Edge history, pending data pulse, shifter and word latch
    typedef struct packed {
        logic clkPrev;
        logic dataPrev;
        logic bitSeen;
        logic [W-1:0] shift;
        logic [$clog2(W)-1:0] count;
        logic [W-1:0] word;
        logic valid;
    } cap_t;

    cap_t r;
    cap_t n;
    logic clkFall;
    logic dataFall;

    // Falling edges of the active-low pulses lead each bit
    always_comb
    begin
        clkFall = r.clkPrev & ~readClockN;
        dataFall = r.dataPrev & ~readDataN;
        n = r;
        n.clkPrev = readClockN;
        n.dataPrev = readDataN;
        n.valid = 1'b0;
        if (!enable)
        begin
            // Outside a read nothing is framed
            n.bitSeen = 1'b0;
            n.count = '0;
        end
        else if (clkFall)
        begin
            // A data pulse since the last clock edge makes a one
            n.shift = {r.shift[W-2:0], r.bitSeen | dataFall};
            n.bitSeen = 1'b0;
            n.count = r.count + 1'b1;
            if (r.count == $clog2(W)'(W - 1))
            begin
                n.word = {r.shift[W-2:0], r.bitSeen | dataFall};
                n.valid = 1'b1;
                n.count = '0;
            end
        end
        else if (dataFall)
            n.bitSeen = 1'b1;
    end

    // State register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            r <= '{1'b1, 1'b1, 1'b0, '0, '0, '0, 1'b0};
        else
            r <= n;
    end

    assign word = r.word;
    assign wordValid = r.valid;
endmodule

// *** disk_select_if_checker.sv ***
// Port assertions for the drive select interface
`timescale 1ns/1ps
module disk_select_if_checker import disk_select_pkg::*; (
    input logic clk,
    input logic rst_n,
    input logic [ADDR_W-1:0] regAddr,
    input logic regWr,
    input logic sector_pulse_n,
    input logic write_protect_n,
    input logic cyl_addr_ack_n,
    input logic drive1_select_n,
    input logic drive2_select_n,
    input logic platter_select_n,
    input logic surface_select_n,
    input logic [CYL_W-1:0] cyl_addr_n,
    input logic cyl_addr_strobe_n,
    input logic restore_n,
    input logic read_gate_n,
    input logic write_gate_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Restore length and head select age, in core cycles
    logic [7:0] restCnt;
    logic [9:0] headCnt;
    // Head age saturates, only the 398 cycle bound matters
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            restCnt <= 8'h00;
            headCnt <= 10'h000;
        end
        else
        begin
            restCnt <= restore_n ? 8'h00 : restCnt + 8'h01;
            if ($changed(surface_select_n))
                headCnt <= 10'h000;
            else if (headCnt != 10'h3FF)
                headCnt <= headCnt + 10'h001;
        end
    end
    gates_apart_a:
        assert property (read_gate_n | write_gate_n) else $error("gate clash");
    one_drive_a:
        assert property (drive1_select_n | drive2_select_n)
        else $error("two drives selected");
    sel_hold_a:
        assert property (!($past(regWr) && $past(regAddr) == UNIT_OFS)
            |-> $stable({drive1_select_n, drive2_select_n, platter_select_n}))
        else $error("select moved without unit write");
    cyl_hold_a:
        assert property (!($past(regWr) && $past(regAddr) == CYL_OFS)
            |-> $stable(cyl_addr_n)) else $error("cylinder moved");
    cyl_range_a:
        assert property (~cyl_addr_n <= CYL_MAX) else $error("cylinder high");
    seek_hold_a:
        assert property (!cyl_addr_strobe_n && restore_n && cyl_addr_ack_n
            && $past(cyl_addr_ack_n) && $past(cyl_addr_ack_n, 2)
            |=> !cyl_addr_strobe_n) else $error("strobe left early");
    seek_release_a:
        assert property ($fell(cyl_addr_ack_n) |-> ##[1:5] cyl_addr_strobe_n)
        else $error("strobe kept after ack");
    restore_strobe_a:
        assert property (!restore_n |-> !cyl_addr_strobe_n)
        else $error("restore without strobe");
    restore_len_a:
        assert property ($rose(restore_n) |-> restCnt == 8'd40)
        else $error("restore length wrong");
    protect_a:
        assert property (!write_protect_n [*5] |-> write_gate_n)
        else $error("write while protected");
    head_settle_a:
        assert property ($fell(write_gate_n) |-> headCnt >= 10'd398)
        else $error("head not settled");
    head_stable_a:
        assert property (!write_gate_n |-> $stable(surface_select_n))
        else $error("head moved in write");
    mark_start_a:
        assert property ($fell(read_gate_n) || $fell(write_gate_n)
            |-> !sector_pulse_n) else $error("gate off the mark");
endmodule
bind disk_select_if disk_select_if_checker chk_u (.clk, .rst_n, .regAddr,
    .regWr, .sector_pulse_n, .write_protect_n, .cyl_addr_ack_n,
    .drive1_select_n, .drive2_select_n, .platter_select_n,
    .surface_select_n, .cyl_addr_n, .cyl_addr_strobe_n, .restore_n,
    .read_gate_n, .write_gate_n);

// *** disk_drive_model.sv ***
// Behavioural drive: rotation, seek answer and read stream
`timescale 1ns/1ps
module disk_drive_model import disk_select_pkg::*; #(
    parameter int SEC_NS = 4000,
    parameter int SECTORS = 8,
    parameter logic [15:0] WORD = 16'hA5C3
) (
    input wire logic [CYL_W-1:0] cylAddrN,
    input wire logic strobeN,
    input wire logic restoreN,
    input wire logic readGateN,
    output logic indexN,
    output logic sectorN,
    output logic [SECTOR_W-1:0] sectorAddrN,
    output logic ackN,
    output logic onCylN,
    output logic readClockN,
    output logic readDataN
);
    // Rotation, scaled short; address moves before each mark
    initial
    begin
        {indexN, sectorN, ackN, onCylN, readClockN, readDataN} = 6'h3B;
        sectorAddrN = '1;
        forever
            for (int s = 0; s < SECTORS; s++)
            begin
                #(SEC_NS - 500) sectorAddrN = ~SECTOR_W'(s);
                #500 sectorN = 1'b0;
                indexN = (s != 0);
                #1000 {sectorN, indexN} = 2'h3;
            end
    end
    // Seek answer, held until 100 ns after the strobe goes back high
    always @(negedge strobeN)
    begin
        #1;
        // Restore gets no ack
        if (restoreN)
        begin
            onCylN = 1'b1;
            #190 ackN = (~cylAddrN > CYL_MAX);
            @(posedge strobeN) #100 ackN = 1'b1;
            onCylN = 1'b0;
        end
    end
    // Clock runs only under read gate, whole words
    always @(negedge readGateN)
        while (!readGateN)
            for (int i = 15; i >= 0; i--)
            begin
                #50 {readClockN, readDataN} = {1'b0, ~WORD[i]};
                #100 {readClockN, readDataN} = 2'h3;
                #50;
            end
endmodule

// *** disk_drive_select_interface_tb.sv ***
// Self-checking bench for the drive select interface
`timescale 1ns/1ps
module disk_drive_select_interface_tb import disk_select_pkg::*;;
    logic clk, rst_n, regWr, regRd;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData, regRdData, rdv;
    logic faultN, protN, swapN, indexN, sectorN, ackN, onCylN, rcN, rdN;
    logic [SECTOR_W-1:0] secN;
    logic d1N, d2N, platN, surfN, strN, restN, rgN, wgN, egN;
    logic [CYL_W-1:0] cylN;
    int fails = 0, totalChecks = 0, cyc = 0, n;
    disk_select_if dut_u (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .index_pulse_n(indexN),
        .sector_pulse_n(sectorN), .sector_addr_n(secN),
        .drive_fault_n(faultN), .write_protect_n(protN),
        .drive1_swap_jumper_n(swapN), .drive2_swap_jumper_n(swapN),
        .cyl_addr_ack_n(ackN), .on_cylinder_n(onCylN), .read_data_n(rdN),
        .read_clock_n(rcN), .drive1_select_n(d1N), .drive2_select_n(d2N),
        .platter_select_n(platN), .surface_select_n(surfN),
        .cyl_addr_n(cylN), .cyl_addr_strobe_n(strN), .restore_n(restN),
        .read_gate_n(rgN), .write_gate_n(wgN), .erase_gate_n(egN));
    disk_drive_model model_u (.cylAddrN(cylN), .strobeN(strN),
        .restoreN(restN), .readGateN(rgN), .indexN(indexN),
        .sectorN(sectorN), .sectorAddrN(secN), .ackN(ackN),
        .onCylN(onCylN), .readClockN(rcN), .readDataN(rdN));
    // Core clock, 25 ns
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            wrap_up();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // One-cycle write
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask
    // One-cycle read; data taken in the cycle after
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 rdv = regRdData;
    endtask
    task automatic t_units();
        for (int j = 0; j < 2; j++)
        begin
            @(posedge clk) swapN <= ~j[0];
            repeat (4) @(posedge clk);
            for (int i = 0; i < 4; i++)
            begin
                wr(UNIT_OFS, 16'h0008 >> i);
                check({d1N, d2N, platN}, {i > 1, i < 2, i[0] ^ j[0]});
            end
            wr(UNIT_OFS, 16'h0003);
            check({d1N, d2N, platN}, {2'b10, ~j[0]});
        end
    endtask
    task automatic t_cyl();
        wr(CYL_OFS, 16'h0197);
        check(cylN, 9'h068);
        wr(CYL_OFS, 16'h0198);
        check(cylN, 9'h068);
        rd(STATUS_OFS);
        check(rdv[14], 1'b1);
        rd(4'hF);
        check(rdv, 16'h0000);
    endtask
    task automatic t_seek();
        wr(CTRL_OFS, 16'h0021);
        check({strN, surfN}, 2'b00);
        n = 0;
        while (n++ < 200 && !strN) @(negedge clk);
        check({strN, ackN}, 2'b10);
    endtask
    task automatic t_restore();
        wr(CTRL_OFS, 16'h0002);
        n = 0;
        @(negedge clk);
        while (n < 100 && !restN)
        begin
            n++;
            @(negedge clk);
        end
        check(16'(n), 16'd40);
    endtask
    // Read at sector 3
    task automatic t_read();
        wr(TARGET_OFS, 16'h0003);
        wr(CTRL_OFS, 16'h0004);
        n = 0;
        while (n++ < 2000 && rgN) @(negedge clk);
        check(sectorN, 1'b0);
        rd(STATUS_OFS);
        check({rdv[12:11], rdv[6:0]}, 9'h1C3);
        n = 0;
        do rd(STATUS_OFS); while (n++ < 400 && !rdv[13]);
        rd(WORD_OFS);
        check(rdv, 16'hA5C3);
        wr(CTRL_OFS, 16'h0010);
    endtask
    // Protected write refused, then a write cut by a fault
    task automatic t_write();
        @(posedge clk) protN <= 1'b0;
        repeat (4) @(posedge clk);
        wr(CTRL_OFS, 16'h0008);
        n = 0;
        while (n++ < 1700 && wgN) @(negedge clk);
        rd(STATUS_OFS);
        check({wgN, rdv[15]}, 2'b11);
        @(posedge clk) protN <= 1'b1;
        repeat (4) @(posedge clk);
        wr(CTRL_OFS, 16'h0008);
        n = 0;
        while (n++ < 2000 && wgN) @(negedge clk);
        check({wgN, egN}, 2'b00);
        @(posedge clk) faultN <= 1'b0;
        repeat (6) @(negedge clk);
        check(wgN, 1'b1);
        @(posedge clk) faultN <= 1'b1;
        wr(CTRL_OFS, 16'h0010);
    endtask
    // Main sequence
    initial
    begin
        {rst_n, regWr, regRd} = 3'h0;
        regAddr = '0;
        regWrData = '0;
        {faultN, protN, swapN} = 3'h7;
        repeat (6) @(posedge clk);
        check({d1N, d2N, platN, strN, restN, rgN, wgN, cylN}, 16'hFFFF);
        rst_n <= 1'b1;
        t_units();
        t_cyl();
        t_seek();
        t_restore();
        t_read();
        t_write();
        wrap_up();
    end
endmodule
